//--- hdl/flash_host.sv
// host sequencer that drives flash command write sequences from a register port
`timescale 1ns/1ps
// How it works
// (RQ1) device: dynamic bit clear, or solid clear with temp bit set, protects
// (RQ2) device: solid-bits lock set refuses every solid protect bit change
// (RQ3) device: lock clear lets program/erase commands change solid bits
// (RQ4) device: separate one-time-programmable security region of 128 words
// (RQ5) security lock state answers factory or sector protect verify read
// (RQ6) device: factory-locked part protected from start, indicator reads 1
// (RQ7) device: customer-lockable part starts unprotected, indicator reads 0
// (RQ8) device: factory part holds 16-byte serial number at region start
// (RQ9) device: protected security region never unprotected or altered
// (RQ10) host returns to array reads by exit sequence or hardware reset
// (RQ11) one write of F0 anywhere resets to array read
// (RQ12) AA/55/90 unlock then fourth-cycle read of id or protect status
// (RQ13) unlock plus 88 enters security region; 90 then 00 exits
// (RQ14) six-write erase: 10 at unlock address chip, 30 at sector
// (RQ15) buffer: 25 and count at sector, pairs, 29 confirms; F0 aborts
// (RQ16) program: unlock, A0 at unlock address, then address and data
// (RQ17) B0 suspends, 30 resumes, 98 at 55/AA enters query read
// (RQ18) device: solid bit 0 protects; set singly, erased only all together
// (RQ19) device: power-up or hardware reset restores temp and dynamic bits
// (RQ20) device ignores protected targets and unknown sequences
// (RQ21) unlock and verify addresses follow word or byte bus mode
module flash_host #(
	parameter int ADDR_W = flash_host_pkg::ADDR_W,
	parameter int DATA_W = flash_host_pkg::DATA_W
) (
	input  wire logic              i_clk_sys,
	input  wire logic              i_srst,
	input  wire logic              i_clk_en,
	input  wire logic [7:0]        i_addr,
	input  wire logic [31:0]       i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [31:0]       o_rdata,
	output logic      [ADDR_W-1:0] o_flash_addr,
	output logic      [DATA_W-1:0] o_dq,
	output logic                   o_dq_oe,
	input  wire logic [DATA_W-1:0] i_dq,
	output logic                   o_ce_n,
	output logic                   o_oe_n,
	output logic                   o_we_n,
	output logic                   o_word_mode,
	output logic                   o_flash_rst_n
);
	flash_host_pkg::bus_t  bus;
	flash_host_pkg::cmd_t  cmd;
	flash_host_pkg::step_t st;
	logic [2:0]        idx;
	logic [7:0]        cnt;
	logic [7:0]        rst_cnt;
	logic [ADDR_W-1:0] tgt;
	logic [DATA_W-1:0] wreg;
	logic              byte_mode;
	logic              sec;
	logic              buf_open;
	logic [DATA_W-1:0] rd_word;
	logic [DATA_W-1:0] dq_s1;
	logic [DATA_W-1:0] dq_s2;
	logic              start;
	logic              hw_req;
	logic              done;

	// step table: each command is a short list of bus cycles
	function automatic flash_host_pkg::step_t step_of(flash_host_pkg::cmd_t c,
			logic [2:0] i);
		flash_host_pkg::step_t s;
		s = '{asel: flash_host_pkg::A_U1, dreg: 1'b0, code: flash_host_pkg::CD_AA,
			rd: 1'b0, last: 1'b0};
		if (i == 3'd1 || i == 3'd4) begin
			s.asel = flash_host_pkg::A_U2;
			s.code = flash_host_pkg::CD_55;
		end
		unique case (c)
			flash_host_pkg::C_RST: begin
				s = '{flash_host_pkg::A_ANY, 1'b0, flash_host_pkg::CD_RESET, 1'b0, 1'b1}; // [RQ11]
			end
			flash_host_pkg::C_ID_MFR, flash_host_pkg::C_FACT_VER, flash_host_pkg::C_PROT_VER: begin
				if (i == 3'd2) s.code = flash_host_pkg::CD_AUTOSEL; // [RQ12]
				if (i == 3'd3) begin
					s.rd = 1'b1;
					s.last = 1'b1;
					s.asel = (c == flash_host_pkg::C_ID_MFR) ? flash_host_pkg::A_ANY :
						(c == flash_host_pkg::C_FACT_VER) ? flash_host_pkg::A_FACT :
						flash_host_pkg::A_VER; // [RQ5] [RQ12]
				end
			end
			flash_host_pkg::C_SEC_ENTER: begin
				if (i == 3'd2) begin
					s.code = flash_host_pkg::CD_SEC_ENTER; // [RQ13]
					s.last = 1'b1;
				end
			end
			flash_host_pkg::C_SEC_EXIT: begin
				if (i == 3'd2) s.code = flash_host_pkg::CD_AUTOSEL;
				if (i == 3'd3) begin
					s.asel = flash_host_pkg::A_ANY;
					s.code = flash_host_pkg::CD_EXIT_TAIL; // [RQ13]
					s.last = 1'b1;
				end
			end
			flash_host_pkg::C_PROG: begin
				if (i == 3'd2) s.code = flash_host_pkg::CD_PROG; // [RQ16]
				if (i == 3'd3) begin
					s.asel = flash_host_pkg::A_TGT;
					s.dreg = 1'b1;
					s.last = 1'b1;
				end
			end
			flash_host_pkg::C_CHIP_ERASE, flash_host_pkg::C_SECT_ERASE: begin
				if (i == 3'd2) s.code = flash_host_pkg::CD_ERASE; // [RQ14]
				if (i == 3'd5) begin
					s.last = 1'b1;
					if (c == flash_host_pkg::C_SECT_ERASE) begin
						s.asel = flash_host_pkg::A_TGT;
						s.code = flash_host_pkg::CD_SECT;
					end else begin
						s.code = flash_host_pkg::CD_CHIP;
					end
				end
			end
			flash_host_pkg::C_BUF_LOAD: begin
				if (i == 3'd2) begin
					s.asel = flash_host_pkg::A_TGT;
					s.code = flash_host_pkg::CD_BUF_LOAD; // [RQ15]
				end
				if (i == 3'd3) begin
					s.asel = flash_host_pkg::A_TGT;
					s.dreg = 1'b1;
					s.last = 1'b1;
				end
			end
			flash_host_pkg::C_BUF_WORD: begin
				s = '{flash_host_pkg::A_TGT, 1'b1, flash_host_pkg::CD_EXIT_TAIL, 1'b0, 1'b1};
			end
			flash_host_pkg::C_BUF_CONF: begin
				s = '{flash_host_pkg::A_TGT, 1'b0, flash_host_pkg::CD_BUF_CONF, 1'b0, 1'b1};
			end
			flash_host_pkg::C_BUF_ABORT: begin
				if (i == 3'd2) begin
					s.code = flash_host_pkg::CD_RESET; // [RQ15]
					s.last = 1'b1;
				end
			end
			flash_host_pkg::C_SUSPEND: begin
				s = '{flash_host_pkg::A_ANY, 1'b0, flash_host_pkg::CD_SUSPEND, 1'b0, 1'b1};
			end
			flash_host_pkg::C_RESUME: begin
				s = '{flash_host_pkg::A_ANY, 1'b0, flash_host_pkg::CD_RESUME, 1'b0, 1'b1};
			end
			flash_host_pkg::C_QUERY: begin
				s = '{flash_host_pkg::A_QRY, 1'b0, flash_host_pkg::CD_QUERY, 1'b0, 1'b1}; // [RQ17]
			end
			flash_host_pkg::C_ARRAY_RD: begin
				s = '{flash_host_pkg::A_TGT, 1'b0, flash_host_pkg::CD_EXIT_TAIL, 1'b1, 1'b1};
			end
			default: begin
				s = '{flash_host_pkg::A_ANY, 1'b0, flash_host_pkg::CD_RESET, 1'b0, 1'b1};
			end
		endcase
		return s;
	endfunction

	function automatic logic [ADDR_W-1:0] addr_of(flash_host_pkg::asel_t a,
			logic [ADDR_W-1:0] t, logic b);
		unique case (a)
			flash_host_pkg::A_U1:   return b ? flash_host_pkg::UNLK1_B : flash_host_pkg::UNLK1_W;
			flash_host_pkg::A_U2:   return b ? flash_host_pkg::UNLK2_B : flash_host_pkg::UNLK2_W;
			flash_host_pkg::A_QRY:  return b ? flash_host_pkg::QRY_B : flash_host_pkg::QRY_W;
			flash_host_pkg::A_FACT: return b ? flash_host_pkg::FACT_B : flash_host_pkg::FACT_W;
			flash_host_pkg::A_VER:  return t | (b ? flash_host_pkg::VER_B : flash_host_pkg::VER_W);
			flash_host_pkg::A_TGT:  return t;
			default:                return flash_host_pkg::ADDR_ZERO;
		endcase
	endfunction // [RQ21]

	assign st = step_of(cmd, idx);
	// orders arriving while a sequence or reset pulse runs are dropped
	assign start = i_clk_en && i_wr && i_addr == flash_host_pkg::REG_CTRL &&
		bus == flash_host_pkg::B_IDLE && rst_cnt == 8'h00;
	assign hw_req = start && i_wdata[flash_host_pkg::CTRL_HWRST_BIT];
	assign done = bus == flash_host_pkg::B_HOLD && cnt == 8'h00 && st.last;

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			tgt <= '0;
			wreg <= '0;
			byte_mode <= 1'b0;
		end else if (i_clk_en && i_wr) begin
			if (i_addr == flash_host_pkg::REG_ADDR) tgt <= i_wdata[ADDR_W-1:0];
			if (i_addr == flash_host_pkg::REG_DATA) wreg <= i_wdata[DATA_W-1:0];
			if (i_addr == flash_host_pkg::REG_MODE) byte_mode <= i_wdata[0];
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			dq_s1 <= '0;
			dq_s2 <= '0;
		end else if (i_clk_en) begin
			dq_s1 <= i_dq;
			dq_s2 <= dq_s1;
		end
	end

	// hardware reset pulse also drops the host's view of device mode
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			rst_cnt <= 8'h00;
			o_flash_rst_n <= 1'b1;
		end else if (i_clk_en) begin
			if (hw_req) begin
				rst_cnt <= flash_host_pkg::RP_CYC;
				o_flash_rst_n <= 1'b0; // [RQ10] [RQ19]
			end else if (rst_cnt != 8'h00) begin
				rst_cnt <= rst_cnt - 8'h01;
				o_flash_rst_n <= rst_cnt == 8'h01;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			sec <= 1'b0;
			buf_open <= 1'b0;
		end else if (i_clk_en) begin
			if (hw_req) begin
				sec <= 1'b0; // [RQ10]
				buf_open <= 1'b0;
			end else if (done) begin
				if (cmd == flash_host_pkg::C_SEC_ENTER) sec <= 1'b1; // [RQ13]
				if (cmd == flash_host_pkg::C_SEC_EXIT) sec <= 1'b0; // [RQ10]
				if (cmd == flash_host_pkg::C_BUF_LOAD) buf_open <= 1'b1;
				if (cmd == flash_host_pkg::C_BUF_CONF || cmd == flash_host_pkg::C_BUF_ABORT)
					buf_open <= 1'b0; // [RQ15]
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			bus <= flash_host_pkg::B_IDLE;
			cmd <= flash_host_pkg::C_RST;
			idx <= 3'd0;
			cnt <= 8'h00;
			rd_word <= '0;
			o_flash_addr <= '0;
			o_dq <= '0;
			o_dq_oe <= 1'b0;
			o_ce_n <= 1'b1;
			o_oe_n <= 1'b1;
			o_we_n <= 1'b1;
		end else if (i_clk_en) begin
			unique case (bus)
				flash_host_pkg::B_IDLE: begin
					if (start && !hw_req) begin
						cmd <= flash_host_pkg::cmd_t'(i_wdata[flash_host_pkg::CMD_W-1:0]);
						idx <= 3'd0;
						cnt <= flash_host_pkg::SETUP_CYC;
						bus <= flash_host_pkg::B_SETUP;
					end
				end
				flash_host_pkg::B_SETUP: begin
					o_ce_n <= 1'b0;
					o_flash_addr <= addr_of(st.asel, tgt, byte_mode);
					o_dq <= st.dreg ? wreg : {{(DATA_W-8){1'b0}}, st.code};
					o_dq_oe <= !st.rd;
					if (cnt == 8'h00) begin
						o_we_n <= st.rd;
						o_oe_n <= !st.rd;
						cnt <= (st.rd ? flash_host_pkg::RD_CYC : flash_host_pkg::WP_CYC) - 8'h01;
						bus <= flash_host_pkg::B_STROBE;
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
				flash_host_pkg::B_STROBE: begin
					if (cnt == 8'h00) begin
						o_we_n <= 1'b1;
						o_oe_n <= 1'b1;
						if (st.rd) rd_word <= dq_s2; // [RQ12]
						cnt <= flash_host_pkg::WPH_CYC - 8'h01;
						bus <= flash_host_pkg::B_HOLD;
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
				flash_host_pkg::B_HOLD: begin
					if (cnt == 8'h00) begin
						o_dq_oe <= 1'b0;
						if (st.last) begin
							o_ce_n <= 1'b1;
							bus <= flash_host_pkg::B_IDLE;
						end else begin
							idx <= idx + 3'd1;
							cnt <= flash_host_pkg::SETUP_CYC;
							bus <= flash_host_pkg::B_SETUP;
						end
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_rdata <= 32'h0000_0000;
			o_word_mode <= 1'b1;
		end else if (i_clk_en) begin
			o_word_mode <= !byte_mode; // [RQ21]
			o_rdata <= 32'h0000_0000;
			if (i_rd) begin
				unique case (i_addr)
					flash_host_pkg::REG_ADDR: o_rdata[ADDR_W-1:0] <= tgt;
					flash_host_pkg::REG_DATA: o_rdata[DATA_W-1:0] <= wreg;
					flash_host_pkg::REG_MODE: o_rdata[0] <= byte_mode;
					flash_host_pkg::REG_STAT: begin
						o_rdata[flash_host_pkg::STAT_BUSY_BIT] <=
							bus != flash_host_pkg::B_IDLE || rst_cnt != 8'h00;
						o_rdata[flash_host_pkg::STAT_SEC_BIT] <= sec;
						o_rdata[flash_host_pkg::STAT_BUF_BIT] <= buf_open;
						o_rdata[flash_host_pkg::STAT_RD_LSB +: DATA_W] <= rd_word;
					end
					default: o_rdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	a_reset_code: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RQ11]
		$fell(o_we_n) && cmd == flash_host_pkg::C_RST |-> o_dq[7:0] == 8'hF0)
		else $error("reset command not F0");
	a_unlock_first: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RQ12]
		$fell(o_we_n) && idx == 3'd0 && cmd == flash_host_pkg::C_ID_MFR |->
		o_dq[7:0] == 8'hAA && o_flash_addr == (byte_mode ? 25'h0AAA : 25'h0555))
		else $error("first unlock write wrong");
	a_sec_enter: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RQ13]
		done && i_clk_en && cmd == flash_host_pkg::C_SEC_ENTER && !hw_req |=> sec)
		else $error("security entry not tracked");
	a_rst_pulse: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RQ10]
		$fell(o_flash_rst_n) |-> !o_flash_rst_n [*8] ##[1:600] o_flash_rst_n)
		else $error("hardware reset pulse too short or stuck");
	a_chip_final: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RQ14]
		$fell(o_we_n) && cmd == flash_host_pkg::C_CHIP_ERASE && idx == 3'd5 |->
		o_dq[7:0] == 8'h10 && o_flash_addr == (byte_mode ? 25'h0AAA : 25'h0555))
		else $error("chip erase final write wrong");
	a_buf_confirm: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RQ15]
		$fell(o_we_n) && cmd == flash_host_pkg::C_BUF_CONF |->
		o_dq[7:0] == 8'h29 && o_flash_addr == tgt)
		else $error("buffer confirm wrong");
	a_prog_data: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RQ16]
		$fell(o_we_n) && cmd == flash_host_pkg::C_PROG && idx == 3'd3 |->
		o_dq == wreg && o_flash_addr == tgt && !o_we_n [*5])
		else $error("program data write wrong");
	a_suspend_code: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RQ17]
		$fell(o_we_n) && cmd == flash_host_pkg::C_SUSPEND |-> o_dq[7:0] == 8'hB0)
		else $error("suspend code wrong");
endmodule

//--- hdl/flash_host_pkg.sv
// constants, commands and step layout for the flash command sequencer host
package flash_host_pkg;
	localparam int ADDR_W = 25;
	localparam int DATA_W = 16;
	localparam int CMD_W  = 5;
	// software register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_MODE = 8'h0C;
	localparam logic [7:0] REG_STAT = 8'h10;
	localparam int CTRL_HWRST_BIT = 8;
	localparam int STAT_BUSY_BIT  = 0;
	localparam int STAT_SEC_BIT   = 1;
	localparam int STAT_BUF_BIT   = 2;
	localparam int STAT_RD_LSB    = 16;
	// device addresses, word mode then byte mode
	localparam logic [ADDR_W-1:0] UNLK1_W = 25'h0555;
	localparam logic [ADDR_W-1:0] UNLK1_B = 25'h0AAA;
	localparam logic [ADDR_W-1:0] UNLK2_W = 25'h02AA;
	localparam logic [ADDR_W-1:0] UNLK2_B = 25'h0555;
	localparam logic [ADDR_W-1:0] QRY_W   = 25'h0055;
	localparam logic [ADDR_W-1:0] QRY_B   = 25'h00AA;
	localparam logic [ADDR_W-1:0] VER_W   = 25'h0002;
	localparam logic [ADDR_W-1:0] VER_B   = 25'h0004;
	localparam logic [ADDR_W-1:0] FACT_W  = 25'h0003;
	localparam logic [ADDR_W-1:0] FACT_B  = 25'h0006;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 25'h0000;
	// command codes
	localparam logic [7:0] CD_AA = 8'hAA;
	localparam logic [7:0] CD_55 = 8'h55;
	localparam logic [7:0] CD_RESET = 8'hF0;
	localparam logic [7:0] CD_AUTOSEL = 8'h90;
	localparam logic [7:0] CD_SEC_ENTER = 8'h88;
	localparam logic [7:0] CD_EXIT_TAIL = 8'h00;
	localparam logic [7:0] CD_PROG = 8'hA0;
	localparam logic [7:0] CD_ERASE = 8'h80;
	localparam logic [7:0] CD_CHIP = 8'h10;
	localparam logic [7:0] CD_SECT = 8'h30;
	localparam logic [7:0] CD_BUF_LOAD = 8'h25;
	localparam logic [7:0] CD_BUF_CONF = 8'h29;
	localparam logic [7:0] CD_SUSPEND = 8'hB0;
	localparam logic [7:0] CD_RESUME = 8'h30;
	localparam logic [7:0] CD_QUERY = 8'h98;
	// bus timing, figures in ns, counts rounded up
	localparam int CLK_NS = 8;
	localparam int T_SETUP_NS = 10;
	localparam int T_WP_NS = 40;
	localparam int T_WPH_NS = 24;
	localparam int T_ACC_NS = 80;
	localparam int T_RP_NS = 500;
	localparam int SYNC_CYC = 2;
	localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] WP_CYC = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] WPH_CYC = 8'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] RD_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
	localparam logic [7:0] RP_CYC = 8'((T_RP_NS + CLK_NS - 1) / CLK_NS);
	typedef enum logic [CMD_W-1:0] {
		C_RST = 5'h00, C_ID_MFR = 5'h01, C_FACT_VER = 5'h02, C_PROT_VER = 5'h03,
		C_SEC_ENTER = 5'h04, C_SEC_EXIT = 5'h05, C_PROG = 5'h06, C_CHIP_ERASE = 5'h07,
		C_SECT_ERASE = 5'h08, C_BUF_LOAD = 5'h09, C_BUF_WORD = 5'h0A, C_BUF_CONF = 5'h0B,
		C_BUF_ABORT = 5'h0C, C_SUSPEND = 5'h0D, C_RESUME = 5'h0E, C_QUERY = 5'h0F,
		C_ARRAY_RD = 5'h10
	} cmd_t;
	typedef enum logic [2:0] {
		A_U1, A_U2, A_ANY, A_TGT, A_QRY, A_VER, A_FACT
	} asel_t;
	typedef struct packed {
		asel_t      asel;
		logic       dreg;
		logic [7:0] code;
		logic       rd;
		logic       last;
	} step_t;
	typedef enum logic [1:0] {
		B_IDLE = 2'b00, B_SETUP = 2'b01, B_STROBE = 2'b11, B_HOLD = 2'b10
	} bus_t;
endpackage

//--- verification/flash_dev_model.sv
// behavioural flash device answering the host's bus cycles
`timescale 1ns/1ps
module flash_dev_model #(
	parameter logic [15:0] MFR_CODE = 16'h005A, // arbitrary value
	parameter logic [3:0]  DYN      = 4'b1111,
	parameter logic [3:0]  SOLID    = 4'b1111,
	parameter logic [3:0]  TEMP     = 4'b1111,
	parameter logic        FACT_LK  = 1'b1
) (
	input  wire logic        i_ce_n,
	input  wire logic        i_oe_n,
	input  wire logic        i_we_n,
	input  wire logic        i_rst_n,
	input  wire logic        i_word_mode,
	input  wire logic [24:0] i_addr,
	input  wire logic [15:0] i_dq,
	output logic      [15:0] o_dq
);
	logic [1:0]  mode; // 0 array, 1 id, 2 security, 3 query
	logic [2:0]  step;
	logic [3:0]  dyn;
	logic [15:0] val, hold, sw;
	logic [7:0]  c, lo;
	logic [24:0] u1, u2;
	// solid bits have no command here, so a set lock always holds
	initial begin
		mode = 2'd0;
		step = 3'd0;
		dyn  = DYN; // power-up defaults
		hold = 16'h5A5A;
	end
	assign u1 = i_word_mode ? 25'h0555 : 25'h0AAA;
	assign u2 = i_word_mode ? 25'h02AA : 25'h0555;
	assign c  = i_dq[7:0];
	always @(posedge i_we_n or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode <= 2'd0;
			step <= 3'd0;
			dyn  <= DYN;
		end else if (!i_ce_n) begin
			step <= 3'd0;
			case (step)
			3'd0: if (c == 8'hAA && i_addr == u1) step <= 3'd1;
				else if (c == 8'h98 && i_addr == (i_word_mode ? 25'h55 : 25'hAA)) mode <= 2'd3;
				else if (c != 8'hB0 && c != 8'h30) mode <= 2'd0;
			3'd1: if (c == 8'h55 && i_addr == u2) step <= 3'd2; else mode <= 2'd0;
			3'd2: case (c)
				8'h90: if (mode == 2'd2) step <= 3'd3; else mode <= 2'd1;
				8'h88: mode <= 2'd2;
				8'hA0: step <= 3'd4;
				8'h25: step <= 3'd5;
				8'h80, 8'h10, 8'h30: ;
				default: mode <= 2'd0; // abort or unknown code
				endcase
			3'd3: if (c == 8'h00) mode <= 2'd0;
			3'd5: step <= 3'd6;
			3'd6: if (c == 8'hAA && i_addr == u1) step <= 3'd1;
				else if (c != 8'h29) step <= 3'd6;
			default: ; // data is never stored, so a locked region cannot change
			endcase
		end
	end
	assign sw = {8'hE5, 1'b0, i_word_mode ? i_addr[6:0] : i_addr[7:1]};
	assign lo = i_addr[7:0];
	always_comb begin
		case (mode)
		2'd1: if (lo == 8'h00) val = MFR_CODE;
			else if (lo == (i_word_mode ? 8'h03 : 8'h06)) val = {8'h00, FACT_LK, 7'h19};
			else if (lo == (i_word_mode ? 8'h02 : 8'h04))
				val = {15'h0, ~dyn[i_addr[17:16]] | (~SOLID[i_addr[17:16]] & TEMP[i_addr[17:16]])};
			else val = 16'h0000;
		2'd2: val = i_word_mode ? sw : {8'h00, i_addr[0] ? sw[15:8] : sw[7:0]};
		default: val = i_addr[15:0] ^ 16'hA5A5;
		endcase
	end
	// released bus shows the inverse, so a stale sample cannot pass
	always @(posedge i_oe_n) hold <= ~val;
	assign o_dq = (!i_ce_n && !i_oe_n) ? val : hold;
endmodule

//--- verification/tb_flash_host.sv
// self-checking bench for the flash command host
`timescale 1ns/1ps
module tb_flash_host;
	localparam logic [3:0] DYN = 4'b1110;
	localparam logic [3:0] SOLID = 4'b0101;
	localparam logic [3:0] TEMP = 4'b0011;
	localparam logic [15:0] MFR = 16'h005A; // arbitrary value
	typedef struct packed {logic any; logic [24:0] a; logic [15:0] d;} wnote_t;
	typedef struct packed {logic [31:0] m; logic [31:0] v;} rnote_t;
	logic        i_clk_sys = 1'b0, i_srst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, rd_q1 = 1'b0;
	logic        mon_en = 1'b0, bm = 1'b0, clk_en = 1'b1;
	logic [7:0]  i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0000_0000, o_rdata, rv;
	logic [24:0] o_flash_addr, u1, u2, ta;
	logic [15:0] o_dq, dq_w, mdq, td;
	logic        o_dq_oe, o_ce_n, o_oe_n, o_we_n, o_word_mode, o_flash_rst_n;
	int          n_errors = 0, n_checks = 0, seed, cnt;
	wnote_t      wq[$], wn;
	rnote_t      rq[$], rn;
	assign dq_w = o_dq_oe ? o_dq : mdq;
	flash_host dut_u (
		.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_clk_en(clk_en), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_flash_addr(o_flash_addr), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .i_dq(dq_w),
		.o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_word_mode(o_word_mode),
		.o_flash_rst_n(o_flash_rst_n)
	);
	flash_dev_model #(.MFR_CODE(MFR), .DYN(DYN), .SOLID(SOLID), .TEMP(TEMP), .FACT_LK(1'b1)) dev_u (
		.i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_rst_n(o_flash_rst_n),
		.i_word_mode(o_word_mode), .i_addr(o_flash_addr), .i_dq(dq_w), .o_dq(mdq)
	);
	initial begin
		forever #4 i_clk_sys = ~i_clk_sys;
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic bad(input string s);
		n_errors++;
		$display("unexpected at %0t: %s", $time, s);
	endtask
	task automatic chk(input logic ok, input string s);
		n_checks++;
		if (ok !== 1'b1) bad(s);
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		@(posedge i_clk_sys);
		i_rd <= 1'b1;
		i_addr <= a;
		rq.push_back({m, v});
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1 rv = o_rdata;
	endtask
	task automatic stat_is(input logic [15:0] v);
		reg_rd(8'h10, 32'hFFFF_0000, {v, 16'h0000});
	endtask
	task automatic poll();
		for (int i = 0; i < 300; i++) begin
			reg_rd(8'h10, '0, '0);
			if (rv[0] === 1'b0) return;
		end
		bad("busy never cleared");
		end_sim();
	endtask
	task automatic note(input logic any, input logic [24:0] a, input logic [15:0] d);
		wq.push_back({any, a, d});
	endtask
	task automatic unlk();
		note(1'b0, u1, 16'h00AA);
		note(1'b0, u2, 16'h0055);
	endtask
	task automatic seq3(input logic [15:0] cd);
		unlk();
		note(1'b0, u1, cd);
	endtask
	task automatic run(input logic [4:0] c, input logic [24:0] a, input logic [15:0] d);
		case (c)
		5'd0: note(1'b1, '0, 16'h00F0);
		5'd4: seq3(16'h0088);
		5'd5: begin
			seq3(16'h0090);
			note(1'b1, '0, 16'h0000);
		end
		5'd6: begin
			seq3(16'h00A0);
			note(1'b0, a, d);
		end
		5'd7, 5'd8: begin
			seq3(16'h0080);
			unlk();
			note(1'b0, c == 5'd7 ? u1 : a, c == 5'd7 ? 16'h0010 : 16'h0030);
		end
		5'd9: begin
			unlk();
			note(1'b0, a, 16'h0025);
			note(1'b0, a, d);
		end
		5'd10: note(1'b0, a, d);
		5'd11: note(1'b0, a, 16'h0029);
		5'd12: seq3(16'h00F0);
		5'd13: note(1'b1, '0, 16'h00B0);
		5'd14: note(1'b1, '0, 16'h0030);
		5'd15: note(1'b0, bm ? 25'h00AA : 25'h0055, 16'h0098);
		5'd16: ;
		default: seq3(16'h0090);
		endcase
		reg_wr(8'h04, 32'(a));
		reg_wr(8'h08, 32'(d));
		reg_wr(8'h00, 32'(c));
		poll();
	endtask
	function automatic logic [15:0] electronic_serial_number(input int k, input logic b);
		logic [15:0] w;
		w = {8'hE5, 1'b0, b ? 7'(k >> 1) : 7'(k)};
		return b ? {8'h00, k[0] ? w[15:8] : w[7:0]} : w;
	endfunction
	// write monitor: every falling-then-rising write strobe takes the oldest note
	always @(posedge o_we_n) if (mon_en) begin
		n_checks++;
		if (wq.size() == 0) bad("bus write with no note");
		else begin
			wn = wq.pop_front();
			if (o_dq !== wn.d || o_dq_oe !== 1'b1 || o_ce_n !== 1'b0 || (!wn.any && o_flash_addr !== wn.a))
				bad("bus write address or data");
		end
	end
	always @(posedge i_clk_sys) begin
		rd_q1 <= i_rd;
		if (rd_q1) begin
			rn = rq.pop_front();
			if (rn.m !== '0) begin
				n_checks++;
				if ((o_rdata & rn.m) !== rn.v) bad("register read data");
			end
		end
	end
	initial begin
		repeat (90000) @(posedge i_clk_sys);
		bad("run timed out");
		end_sim();
	end
	initial begin
		seed = 32'h9eaf_ee36;
		repeat (5) @(posedge i_clk_sys);
		i_srst <= 1'b0;
		@(posedge i_clk_sys);
		#1 chk(o_ce_n === 1'b1 && o_we_n === 1'b1 && o_dq_oe === 1'b0 && o_flash_rst_n === 1'b1, "idle");
		mon_en = 1'b1;
		reg_rd(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
		for (int b = 0; b < 2; b++) begin
			bm = b[0];
			u1 = bm ? 25'h0AAA : 25'h0555;
			u2 = bm ? 25'h0555 : 25'h02AA;
			reg_wr(8'h0C, {31'h0, bm});
			repeat (3) @(posedge i_clk_sys);
			#1 chk(o_word_mode === !bm, "bus width pin");
			run(5'd1, '0, '0);
			stat_is(MFR);
			run(5'd2, '0, '0);
			stat_is(16'h0099);
			for (int s = 0; s < 4; s++) begin
				run(5'd3, 25'(s) << 16, '0);
				stat_is({15'h0, !DYN[s] | (!SOLID[s] & TEMP[s])});
			end
			run(5'd0, '0, '0);
			ta = 25'($random(seed)) & 25'h00_FFFF;
			td = 16'($random(seed));
			run(5'd16, ta, '0);
			stat_is(ta[15:0] ^ 16'hA5A5);
			run(5'd4, '0, '0);
			reg_rd(8'h10, 32'h0000_0002, 32'h0000_0002);
			for (int k = 0; k < (bm ? 16 : 8); k++) begin
				run(5'd16, 25'(k), '0);
				stat_is(electronic_serial_number(k, bm));
			end
			run(5'd5, '0, '0);
			run(5'd16, ta, '0);
			stat_is(ta[15:0] ^ 16'hA5A5);
			run(5'd6, ta, td);
			reg_rd(8'h04, 32'h01FF_FFFF, 32'(ta));
			reg_rd(8'h08, 32'h0000_FFFF, {16'h0000, td});
			reg_rd(8'h0C, 32'h0000_0001, {31'h0, bm});
			for (int c = 7; c < 16; c++) begin
				run(5'(c), 25'h1_0000, c == 9 ? 16'h0003 : td);
				if (c == 9 || c == 11) reg_rd(8'h10, 32'h0000_0004, {29'h0, c == 9, 2'h0});
			end
			$display("command set in bus width %0d done", b);
		end
		note(1'b1, '0, 16'h00F0);
		reg_wr(8'h00, 32'h0000_0000);
		reg_wr(8'h00, 32'h0000_000D);
		poll();
		// a strobe taken while the enable is low must leave no trace
		@(posedge i_clk_sys);
		clk_en <= 1'b0;
		reg_wr(8'h00, 32'h0000_0000);
		clk_en <= 1'b1;
		reg_rd(8'h10, 32'h0000_0001, 32'h0000_0000);
		note(1'b1, '0, 16'h00F0);
		reg_wr(8'h00, 32'h0000_001F);
		poll();
		$display("clock enable freeze and unknown code done");
		run(5'd4, '0, '0);
		reg_wr(8'h00, 32'h0000_0100);
		cnt = 0;
		for (int k = 0; k < 300; k++) begin
			#1 if (o_flash_rst_n === 1'b0) cnt++;
			else if (cnt > 0) break;
			@(posedge i_clk_sys);
		end
		chk(cnt == 63, "hardware reset width");
		reg_rd(8'h10, 32'h0000_0002, 32'h0000_0000);
		run(5'd16, ta, '0);
		stat_is(ta[15:0] ^ 16'hA5A5);
		chk(wq.size() == 0, "bus writes missing");
		$display("refusal and hardware reset done");
		end_sim();
	end
endmodule
